/* File: core/flash_host_ctrl.sv */
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
module flash_host_ctrl #(
	parameter int AW = flash_host_pkg::ADDR_W
) (
	input  wire logic          CLK,
	input  wire logic          RST,
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [7:0]    PADDR,
	input  wire logic [31:0]   PWDATA,
	output logic [31:0]        PRDATA,
	output logic               PREADY,
	output logic               PSLVERR,
	output logic [AW-1:0]      FL_ADDR,
	output logic               FL_CE_N,
	output logic               FL_OE_N,
	output logic               FL_WE_N,
	output logic [7:0]         FL_DQ_O,
	output logic               FL_DQ_OE,
	input  wire logic [7:0]    FL_DQ_I
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SEQ    = 3'h1,
		ST_SEQW   = 3'h3,
		ST_POLL   = 3'h2,
		ST_POLLW  = 3'h6,
		ST_SETTLE = 3'h7,
		ST_FINAL  = 3'h5,
		ST_FINALW = 3'h4
	} st_t;

	st_t           st_ff, nxt_st;
	cmd_t          cmd_ff, nxt_cmd;
	logic [2:0]    idx_ff, nxt_idx;
	logic [8:0]    cnt_ff, nxt_cnt;
	logic [AW-1:0] addr_ff, nxt_addr;
	logic [7:0]    wdata_ff, nxt_wdata;
	logic [7:0]    rdata_ff, nxt_rdata;
	logic [7:0]    maker_ff, nxt_maker;
	logic [7:0]    part_ff, nxt_part;
	logic          done_ff, nxt_done;
	logic          err_ff, nxt_err;
	logic          idmode_ff, nxt_idmode;
	logic          prev6_ff, nxt_prev6;
	logic          first_ff, nxt_first;
	logic          cstart_ff, nxt_cstart;
	logic          cwr_ff, nxt_cwr;
	logic [AW-1:0] caddr_ff, nxt_caddr;
	logic [7:0]    cdata_ff, nxt_cdata;
	logic          pready_ff, nxt_pready;
	logic          pslverr_ff, nxt_pslverr;
	logic [31:0]   prdata_ff, nxt_prdata;
	logic          c_done;
	logic [7:0]    c_rdata;
	logic [AW+7:0] step;

	// ------------------------------------------------------------
	// unlock and command sequences
	// ------------------------------------------------------------
	// returns {address, data} of write i of a command
	function automatic logic [AW+7:0] seq_word(cmd_t c, logic [2:0] i,
	                                         logic [AW-1:0] a, logic [7:0] d);
		logic [AW-1:0] sa;
		sa = (a >> SECTOR_LSB) << SECTOR_LSB;
		case (i)
			3'h0: seq_word = (c == CMD_ID_EXIT_S) ? {AW'(0), D_ID_EXIT}
			                                      : {AW'(UNLOCK_A1), D_UNLOCK1};
			3'h1: seq_word = {AW'(UNLOCK_A2), D_UNLOCK2};
			3'h2: begin
				case (c)
					CMD_PROG:     seq_word = {AW'(UNLOCK_A1), D_PROGRAM};
					CMD_ID_ENTER: seq_word = {AW'(UNLOCK_A1), D_ID_ENTER};
					CMD_ID_EXIT:  seq_word = {AW'(UNLOCK_A1), D_ID_EXIT};
					default:      seq_word = {AW'(UNLOCK_A1), D_ERASE};
				endcase
			end
			3'h3: seq_word = (c == CMD_PROG) ? {a, d} : {AW'(UNLOCK_A1), D_UNLOCK1};
			3'h4: seq_word = {AW'(UNLOCK_A2), D_UNLOCK2};
			default: seq_word = (c == CMD_SECTOR) ? {sa, D_SECTOR}
			                                      : {AW'(UNLOCK_A1), D_CHIP};
		endcase
	endfunction

	function automatic logic [2:0] seq_len(cmd_t c);
		case (c)
			CMD_PROG:                seq_len = 3'h4;
			CMD_SECTOR, CMD_CHIP:    seq_len = 3'h6;
			CMD_ID_ENTER, CMD_ID_EXIT: seq_len = 3'h3;
			CMD_ID_EXIT_S:           seq_len = 3'h1;
			default:                 seq_len = 3'h0;
		endcase
	endfunction

	assign step = seq_word(cmd_ff, idx_ff, addr_ff, wdata_ff);

	// ------------------------------------------------------------
	// register slave and operation sequencer
	// ------------------------------------------------------------
	// one wait state: ready rises in the second access cycle
	always_comb begin
		nxt_st = st_ff;       nxt_cmd = cmd_ff;       nxt_idx = idx_ff;
		nxt_cnt = cnt_ff;     nxt_addr = addr_ff;     nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff; nxt_maker = maker_ff;   nxt_part = part_ff;
		nxt_done = done_ff;   nxt_err = err_ff;       nxt_idmode = idmode_ff;
		nxt_prev6 = prev6_ff; nxt_first = first_ff;   nxt_cstart = 1'b0;
		nxt_cwr = cwr_ff;     nxt_caddr = caddr_ff;   nxt_cdata = cdata_ff;
		nxt_pready = 1'b0;    nxt_pslverr = 1'b0;     nxt_prdata = prdata_ff;
		if (PSEL && PENABLE && !pready_ff) begin
			nxt_pready = 1'b1;
			nxt_prdata = 32'h0000_0000;
			case (PADDR)
				OFS_CTRL:   nxt_prdata[2:0] = cmd_ff;
				OFS_ADDR:   nxt_prdata[AW-1:0] = addr_ff;
				OFS_DATA:   nxt_prdata[7:0] = wdata_ff;
				OFS_STATUS: nxt_prdata[3:0] = {idmode_ff, err_ff, done_ff, st_ff != ST_IDLE};
				OFS_RESULT: nxt_prdata[23:0] = {part_ff, maker_ff, rdata_ff};
				default:    nxt_pslverr = 1'b1;
			endcase
		end
		if (PSEL && PENABLE && pready_ff && PWRITE) begin
			case (PADDR)
				OFS_ADDR: nxt_addr = PWDATA[AW-1:0];
				OFS_DATA: nxt_wdata = PWDATA[7:0];
				OFS_STATUS: begin
					// clear first; a completion later in this block wins
					if (PWDATA[STAT_DONE_BIT]) nxt_done = 1'b0;
					if (PWDATA[STAT_ERR_BIT])  nxt_err = 1'b0;
				end
				OFS_CTRL: begin
					// orders while busy are dropped, never queued
					if (PWDATA[CTRL_GO_BIT] && st_ff == ST_IDLE) begin
						nxt_cmd   = cmd_t'(PWDATA[2:0]);
						nxt_idx   = 3'h0;
						nxt_first = 1'b1;
						nxt_st    = (seq_len(cmd_t'(PWDATA[2:0])) != 3'h0) ? ST_SEQ : ST_FINAL;
					end
				end
				default: ;
			endcase
		end
		case (st_ff)
			ST_IDLE: ;
			ST_SEQ: begin
				nxt_cstart = 1'b1;
				nxt_cwr    = 1'b1;
				{nxt_caddr, nxt_cdata} = step;
				nxt_st     = ST_SEQW;
			end
			ST_SEQW: begin
				if (c_done) begin
					nxt_idx = idx_ff + 3'h1;
					if (idx_ff + 3'h1 != seq_len(cmd_ff)) begin
						nxt_st = ST_SEQ;
					end else if (cmd_ff == CMD_ID_ENTER) begin
						nxt_idmode = 1'b1;
						nxt_done = 1'b1;
						nxt_st = ST_IDLE;
					end else if (cmd_ff == CMD_ID_EXIT || cmd_ff == CMD_ID_EXIT_S) begin
						nxt_idmode = 1'b0;
						nxt_done = 1'b1;
						nxt_st = ST_IDLE;
					end else begin
						nxt_st = ST_POLL;
					end
				end
			end
			ST_POLL: begin
				nxt_cstart = 1'b1;
				nxt_cwr    = 1'b0;
				nxt_caddr  = addr_ff;
				nxt_st     = ST_POLLW;
			end
			ST_POLLW: begin
				if (c_done) begin
					nxt_prev6 = c_rdata[6];
					nxt_first = 1'b0;
					// toggling bit frozen across two reads means finished
					if (!first_ff && c_rdata[6] == prev6_ff) begin
						nxt_cnt = SETTLE_LOAD;
						nxt_st  = ST_SETTLE;
					end else begin
						nxt_st = ST_POLL;
					end
				end
			end
			ST_SETTLE: begin
				if (cnt_ff == 9'h000)
					nxt_st = ST_FINAL;
				else
					nxt_cnt = cnt_ff - 9'h001;
			end
			ST_FINAL: begin
				nxt_cstart = 1'b1;
				nxt_cwr    = 1'b0;
				nxt_caddr  = (cmd_ff != CMD_ID_READ) ? addr_ff :
				             (idx_ff == 3'h0) ? AW'(ID_MAKER_A) : AW'(ID_PART_A);
				nxt_st     = ST_FINALW;
			end
			ST_FINALW: begin
				if (c_done) begin
					nxt_st   = ST_IDLE;
					nxt_done = 1'b1;
					case (cmd_ff)
						CMD_ID_READ: begin
							if (idx_ff == 3'h0) begin
								nxt_maker = c_rdata;
								nxt_idx   = 3'h1;
								nxt_st    = ST_FINAL;
								nxt_done  = done_ff;
							end else begin
								nxt_part = c_rdata;
							end
						end
						CMD_PROG: begin
							nxt_rdata = c_rdata;
							if (c_rdata != wdata_ff) nxt_err = 1'b1;
						end
						CMD_SECTOR, CMD_CHIP: begin
							nxt_rdata = c_rdata;
							if (c_rdata != ERASED_BYTE) nxt_err = 1'b1;
						end
						default: nxt_rdata = c_rdata;
					endcase
				end
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_ff <= ST_IDLE;    cmd_ff <= CMD_READ;  idx_ff <= 3'h0;
			cnt_ff <= 9'h000;    addr_ff <= '0;       wdata_ff <= 8'h00;
			rdata_ff <= 8'h00;   maker_ff <= 8'h00;   part_ff <= 8'h00;
			done_ff <= 1'b0;     err_ff <= 1'b0;      idmode_ff <= 1'b0;
			prev6_ff <= 1'b0;    first_ff <= 1'b0;    cstart_ff <= 1'b0;
			cwr_ff <= 1'b0;      caddr_ff <= '0;      cdata_ff <= 8'h00;
			pready_ff <= 1'b0;   pslverr_ff <= 1'b0;  prdata_ff <= 32'h0000_0000;
		end else begin
			st_ff <= nxt_st;       cmd_ff <= nxt_cmd;       idx_ff <= nxt_idx;
			cnt_ff <= nxt_cnt;     addr_ff <= nxt_addr;     wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata; maker_ff <= nxt_maker;   part_ff <= nxt_part;
			done_ff <= nxt_done;   err_ff <= nxt_err;       idmode_ff <= nxt_idmode;
			prev6_ff <= nxt_prev6; first_ff <= nxt_first;   cstart_ff <= nxt_cstart;
			cwr_ff <= nxt_cwr;     caddr_ff <= nxt_caddr;   cdata_ff <= nxt_cdata;
			pready_ff <= nxt_pready; pslverr_ff <= nxt_pslverr; prdata_ff <= nxt_prdata;
		end
	end

	assign PREADY  = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign PRDATA  = prdata_ff;

	// ------------------------------------------------------------
	// pin cycle engine
	// ------------------------------------------------------------
	flash_bus_cycle #(.AW(AW)) u_cycle (
		.clk      (CLK),
		.rst      (RST),
		.start    (cstart_ff),
		.wr       (cwr_ff),
		.addr     (caddr_ff),
		.wdata    (cdata_ff),
		.dq_i     (FL_DQ_I),
		.done_ff  (c_done),
		.rdata_ff (c_rdata),
		.addr_ff  (FL_ADDR),
		.ce_n_ff  (FL_CE_N),
		.oe_n_ff  (FL_OE_N),
		.we_n_ff  (FL_WE_N),
		.dq_o_ff  (FL_DQ_O),
		.dq_oe_ff (FL_DQ_OE)
	);

	// ------------------------------------------------------------
	// sequencing checks
	// ------------------------------------------------------------
	property p_settle_before_final;
		@(posedge CLK) disable iff (RST)
		$rose(st_ff == ST_FINAL) && cmd_ff != CMD_READ && cmd_ff != CMD_ID_READ
		|-> $past(st_ff) == ST_SETTLE && $past(cnt_ff) == 9'h000;
	endproperty
	a_settle_before_final: assert property (p_settle_before_final)
		else $error("final read without the settle wait");

	property p_stop_on_frozen;
		@(posedge CLK) disable iff (RST)
		$rose(st_ff == ST_SETTLE) |-> $past(c_rdata[6]) == $past(prev6_ff) && !$past(first_ff);
	endproperty
	a_stop_on_frozen: assert property (p_stop_on_frozen)
		else $error("polling ended while status bit still toggling");

	property p_prog_four_writes;
		@(posedge CLK) disable iff (RST)
		$rose(st_ff == ST_POLL) && cmd_ff == CMD_PROG |-> idx_ff == 3'h4;
	endproperty
	a_prog_four_writes: assert property (p_prog_four_writes)
		else $error("program polled without four writes");

	property p_erase_six_writes;
		@(posedge CLK) disable iff (RST)
		$rose(st_ff == ST_POLL) && (cmd_ff == CMD_SECTOR || cmd_ff == CMD_CHIP)
		|-> idx_ff == 3'h6;
	endproperty
	a_erase_six_writes: assert property (p_erase_six_writes)
		else $error("erase polled without six writes");

	property p_no_order_when_busy;
		@(posedge CLK) disable iff (RST)
		st_ff != ST_IDLE ##1 st_ff != ST_IDLE |-> $stable(cmd_ff);
	endproperty
	a_no_order_when_busy: assert property (p_no_order_when_busy)
		else $error("command replaced during an operation");

	property p_id_exit_cause;
		@(posedge CLK) disable iff (RST)
		$fell(idmode_ff) |-> $past(cmd_ff) == CMD_ID_EXIT || $past(cmd_ff) == CMD_ID_EXIT_S;
	endproperty
	a_id_exit_cause: assert property (p_id_exit_cause)
		else $error("identification mode left without exit");

endmodule

/* File: core/flash_host_pkg.sv */
package flash_host_pkg;

	// ------------------------------------------------------------
	// register map of the controller, one 32-bit word each
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_DATA   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_RESULT = 8'h10;

	// field positions
	localparam int CTRL_GO_BIT   = 4;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_ERR_BIT  = 2;
	localparam int STAT_ID_BIT   = 3;

	// ------------------------------------------------------------
	// flash geometry and command bytes
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 19;
	localparam int          SECTOR_LSB  = 12;
	localparam logic [15:0] UNLOCK_A1   = 16'h5555;
	localparam logic [15:0] UNLOCK_A2   = 16'h2AAA;
	localparam logic [15:0] ID_MAKER_A  = 16'h0000;
	localparam logic [15:0] ID_PART_A   = 16'h0001;
	localparam logic [7:0]  D_UNLOCK1   = 8'hAA;
	localparam logic [7:0]  D_UNLOCK2   = 8'h55;
	localparam logic [7:0]  D_PROGRAM   = 8'hA0;
	localparam logic [7:0]  D_ERASE     = 8'h80;
	localparam logic [7:0]  D_SECTOR    = 8'h30;
	localparam logic [7:0]  D_CHIP      = 8'h10;
	localparam logic [7:0]  D_ID_ENTER  = 8'h90;
	localparam logic [7:0]  D_ID_EXIT   = 8'hF0;
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;

	// ------------------------------------------------------------
	// timing at 250 MHz
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int STROBE_NS     = 20;
	localparam int READ_NS       = 70;
	localparam int SETTLE_NS     = 1000;
	localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC      = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] STROBE_LOAD = 8'(STROBE_CYC - 1);
	localparam logic [7:0] READ_LOAD   = 8'(READ_CYC + 1);
	localparam logic [8:0] SETTLE_LOAD = 9'(SETTLE_CYC - 1);

	// ------------------------------------------------------------
	// operations software can order
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_READ      = 3'h0,
		CMD_PROG      = 3'h1,
		CMD_SECTOR    = 3'h2,
		CMD_CHIP      = 3'h3,
		CMD_ID_ENTER  = 3'h4,
		CMD_ID_EXIT   = 3'h5,
		CMD_ID_EXIT_S = 3'h6,
		CMD_ID_READ   = 3'h7
	} cmd_t;

endpackage

/* File: core/flash_bus_cycle.sv */
`timescale 1ns/10ps
module flash_bus_cycle #(
	parameter int AW = 19
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic          wr,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	input  wire logic [7:0]    dq_i,
	output logic               done_ff,
	output logic [7:0]         rdata_ff,
	output logic [AW-1:0]      addr_ff,
	output logic               ce_n_ff,
	output logic               oe_n_ff,
	output logic               we_n_ff,
	output logic [7:0]         dq_o_ff,
	output logic               dq_oe_ff
);
	import flash_host_pkg::*;

	typedef enum logic [1:0] {
		E_IDLE  = 2'h0,
		E_SETUP = 2'h1,
		E_ACT   = 2'h3,
		E_END   = 2'h2
	} e_st_t;

	e_st_t       st_ff, nxt_st;
	logic [7:0]  cnt_ff, nxt_cnt;
	logic [7:0]  s1_ff, s2_ff;
	logic        wr_ff, nxt_wr;
	logic        nxt_done, nxt_ce_n, nxt_oe_n, nxt_we_n, nxt_dq_oe;
	logic [7:0]  nxt_rdata, nxt_dq_o;
	logic [AW-1:0] nxt_addr;

	// ------------------------------------------------------------
	// pin cycle sequencing
	// ------------------------------------------------------------
	// one write or read per start; strobes never overlap output gate
	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_ff;
		nxt_wr    = wr_ff;
		nxt_done  = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_addr  = addr_ff;
		nxt_ce_n  = ce_n_ff;
		nxt_oe_n  = oe_n_ff;
		nxt_we_n  = we_n_ff;
		nxt_dq_o  = dq_o_ff;
		nxt_dq_oe = dq_oe_ff;
		case (st_ff)
			E_IDLE: begin
				if (start) begin
					nxt_addr  = addr;
					nxt_wr    = wr;
					nxt_ce_n  = 1'b0;
					nxt_dq_o  = wdata;
					nxt_dq_oe = wr;
					nxt_st    = E_SETUP;
				end
			end
			E_SETUP: begin
				if (wr_ff) begin
					nxt_we_n = 1'b0;
					nxt_cnt  = STROBE_LOAD;
				end else begin
					nxt_oe_n = 1'b0;
					nxt_cnt  = READ_LOAD;                 // covers access plus sync
				end
				nxt_st = E_ACT;
			end
			E_ACT: begin
				if (cnt_ff == 8'h00) begin
					nxt_we_n = 1'b1;                      // byte latched here
					nxt_oe_n = 1'b1;
					if (!wr_ff)
						nxt_rdata = s2_ff;
					nxt_st = E_END;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			E_END: begin
				// data held one cycle past the rising strobe for hold time
				nxt_ce_n  = 1'b1;
				nxt_dq_oe = 1'b0;
				nxt_done  = 1'b1;
				nxt_st    = E_IDLE;
			end
			default: nxt_st = E_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// registers, plus a two-stage synchroniser on the data pins
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		s1_ff <= dq_i;
		s2_ff <= s1_ff;
		if (rst) begin
			st_ff    <= E_IDLE;
			cnt_ff   <= 8'h00;
			wr_ff    <= 1'b0;
			done_ff  <= 1'b0;
			rdata_ff <= 8'h00;
			addr_ff  <= '0;
			ce_n_ff  <= 1'b1;
			oe_n_ff  <= 1'b1;
			we_n_ff  <= 1'b1;
			dq_o_ff  <= 8'h00;
			dq_oe_ff <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			wr_ff    <= nxt_wr;
			done_ff  <= nxt_done;
			rdata_ff <= nxt_rdata;
			addr_ff  <= nxt_addr;
			ce_n_ff  <= nxt_ce_n;
			oe_n_ff  <= nxt_oe_n;
			we_n_ff  <= nxt_we_n;
			dq_o_ff  <= nxt_dq_o;
			dq_oe_ff <= nxt_dq_oe;
		end
	end

	// ------------------------------------------------------------
	// pin protocol checks
	// ------------------------------------------------------------
	property p_no_gate_in_write;
		@(posedge clk) disable iff (rst) !we_n_ff |-> oe_n_ff && !ce_n_ff;
	endproperty
	a_no_gate_in_write: assert property (p_no_gate_in_write)
		else $error("write strobe low with output gate low or chip deselected");

	property p_strobe_width;
		@(posedge clk) disable iff (rst) $fell(we_n_ff) |-> !we_n_ff [*2];
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("write strobe shorter than glitch filter");

	property p_no_drive_on_read;
		@(posedge clk) disable iff (rst) dq_oe_ff |-> oe_n_ff;
	endproperty
	a_no_drive_on_read: assert property (p_no_drive_on_read)
		else $error("host drives data while output gate low");

	property p_select_for_access;
		@(posedge clk) disable iff (rst) !oe_n_ff |-> !ce_n_ff ##1 (!ce_n_ff || oe_n_ff);
	endproperty
	a_select_for_access: assert property (p_select_for_access)
		else $error("output gate low without chip select");

	property p_data_at_latch;
		@(posedge clk) disable iff (rst) $rose(we_n_ff) |-> dq_oe_ff && $stable(dq_o_ff);
	endproperty
	a_data_at_latch: assert property (p_data_at_latch)
		else $error("write data not held at strobe rise");

endmodule

/* File: sim/flash_dev_model.sv */
`timescale 1ns/10ps
module flash_dev_model #(
	parameter int         BUSY_READS = 3,
	parameter logic [7:0] MAKER_ID   = 8'h3C, // arbitrary value
	parameter logic [7:0] PART_ID    = 8'h5A  // arbitrary value
) (
	input  wire logic [18:0] addr,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [7:0]  din,
	output logic [7:0]       dout
);
	logic [7:0] mem [logic [18:0]];
	logic [7:0] val     = '0;
	logic [7:0] pd      = '0;
	logic       id_mode = 1'b0;
	logic       tog     = 1'b0;
	logic       er      = 1'b0;
	int         step    = 0;
	int         busy    = 0;
	realtime    t_fall  = 0.0;
	realtime    t_done  = -1.0e6;

	// unwritten cells read as erased ones
	function automatic logic [7:0] rd(input logic [18:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction

	// command sequencer, one call per accepted strobe
	task automatic seq(input logic [18:0] a, input logic [7:0] d);
		logic ua1;
		logic ua2;
		ua1 = (a[14:0] == 15'h5555);
		ua2 = (a[14:0] == 15'h2AAA);
		if ((step == 0 || (step == 2 && ua1)) && d == 8'hF0)
			id_mode = 1'b0;
		if (step == 2 && ua1 && d == 8'h90)
			id_mode = 1'b1;
		case (step)
			0, 4: step = (ua1 && d == 8'hAA) ? step + 1 : 0;
			1, 5: step = (ua2 && d == 8'h55) ? step + 1 : 0;
			2: step = !ua1 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
			3: begin
				pd = d;
				er = 1'b0;
				busy = BUSY_READS;
				step = 0;
				mem[a] = rd(a) & d;
			end
			default: begin
				er = 1'b1;
				step = 0;
				busy = (d == 8'h30 || (d == 8'h10 && ua1)) ? 2 * BUSY_READS : 0;
				if (d == 8'h30)
					for (int i = 0; i < 4096; i++) mem.delete({a[18:12], 12'(i)});
				if (d == 8'h10 && ua1)
					mem.delete();
			end
		endcase
	endtask

	// ------
	// strobes: short, inhibited or mid-operation ones never reach the sequencer
	// ------
	always @(negedge we_n) t_fall = $realtime;
	always @(posedge we_n) begin
		if (!ce_n && oe_n && $realtime - t_fall >= 5.0 && busy == 0)
			seq(addr, din);
	end

	// reads: status while busy, low bits unreliable for 1 us after the end
	always @(negedge oe_n or negedge ce_n) begin
		if (!ce_n && !oe_n) begin
			if (busy > 0) begin
				tog = ~tog;
				val = {er ? 1'b0 : ~pd[7], tog, 6'h2A ^ {6{tog}}};
				busy--;
				if (busy == 0)
					t_done = $realtime;
			end else if (id_mode)
				val = addr[0] ? PART_ID : MAKER_ID;
			else if ($realtime - t_done < 1000.0)
				val = (rd(addr) & 8'h80) | {1'b0, tog, 6'h15};
			else
				val = rd(addr);
		end
	end
	// released pins show the inverse of the last value, not a stale copy
	assign dout = (!ce_n && !oe_n) ? val : ~val;
endmodule

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
	import flash_host_pkg::*;
	localparam logic [7:0]  MID = 8'h3C; // arbitrary value
	localparam logic [7:0]  PID = 8'h5A; // arbitrary value
	localparam logic [18:0] A   = 19'h1_2345;
	localparam logic [18:0] B   = 19'h1_3000;
	logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, perr;
	logic        ce_n, oe_n, we_n, dq_oe;
	logic [7:0]  PADDR, dq_o, dq_q;
	logic [31:0] PWDATA, PRDATA, q, st, res;
	logic [18:0] fa;
	int          mismatches, samples_checked;
	// the wire level: host wins while it drives
	wire  [7:0]  bus = dq_oe ? dq_o : dq_q;

	flash_host_ctrl uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.FL_ADDR(fa), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_DQ_O(dq_o),
		.FL_DQ_OE(dq_oe), .FL_DQ_I(bus));
	flash_dev_model #(.BUSY_READS(3), .MAKER_ID(MID), .PART_ID(PID)) dev (.addr(fa),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .din(bus), .dout(dq_q));

	// ------
	// reporting
	// ------
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic stall();
		mismatches++;
		give_verdict();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ------
	// bus access: hold everything until pready is seen high
	// ------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		q = PRDATA;
		perr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 50)
			stall();
	endtask
	// one full operation; status and result read, then sticky bits cleared
	task automatic op(input cmd_t c, input logic [18:0] a, input logic [7:0] d);
		int n;
		apb(1'b1, OFS_ADDR, 32'(a));
		apb(1'b1, OFS_DATA, 32'(d));
		apb(1'b1, OFS_CTRL, 32'(c) | (32'h0000_0001 << CTRL_GO_BIT));
		// a second order while busy must be dropped, never queued
		apb(1'b1, OFS_CTRL, 32'(CMD_ID_ENTER) | (32'h0000_0001 << CTRL_GO_BIT));
		apb(1'b0, OFS_CTRL, '0);
		check(q & 32'h0000_0007, 32'(c));
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, '0);
			st = q & 32'h0000_000F;
			n++;
		end while (st[STAT_DONE_BIT] !== 1'b1 && n < 500);
		if (n >= 500)
			stall();
		apb(1'b0, OFS_RESULT, '0);
		res = q;
		apb(1'b1, OFS_STATUS, 32'h0000_0006);
	endtask

	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	// ------
	// main sequence
	// ------
	initial begin
		RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = '0;
		PWDATA = '0;
		mismatches = 0;
		samples_checked = 0;
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		apb(1'b0, OFS_STATUS, '0);
		check(q, 32'h0000_0000);
		apb(1'b0, 8'h14, '0);
		check({q[30:0], perr}, 32'h0000_0001);
		// both exit forms must leave identification mode the same way
		for (int x = 0; x < 2; x++) begin
			op(CMD_ID_ENTER, '0, '0);
			check(st, 32'h0000_000A);
			op(CMD_ID_READ, '0, '0);
			check(res & 32'h00FF_FF00, {8'h00, PID, MID, 8'h00});
			op(x != 0 ? CMD_ID_EXIT_S : CMD_ID_EXIT, '0, '0);
			check(st, 32'h0000_0002);
			op(CMD_READ, 19'h0_0001, '0);
			check(res & 32'h0000_00FF, 32'h0000_00FF);
		end
		op(CMD_PROG, B, 8'h33);
		check(st, 32'h0000_0002);
		op(CMD_PROG, A, 8'h5A);
		check(res & 32'h0000_00FF, 32'h0000_005A);
		op(CMD_SECTOR, A, '0);
		check({16'h0000, st[7:0], res[7:0]}, 32'h0000_02FF);
		op(CMD_READ, B, '0);
		check(res & 32'h0000_00FF, 32'h0000_0033);
		op(CMD_CHIP, '0, '0);
		check(st, 32'h0000_0002);
		op(CMD_READ, B, '0);
		check(res & 32'h0000_00FF, 32'h0000_00FF);
		give_verdict();
	end
endmodule
